// ### verilog/i2c_core_regs.svh
// Offsets, field positions, reset values and timing of the two-wire interface
`ifndef I2C_CORE_REGS_SVH
`define I2C_CORE_REGS_SVH
// ==========================================
// Functional notes
// - Speed select bit picks standard or fast mode and survives disable.
// - Divider N gives SCL = clk/(2(N+2)) standard, clk/(3(N+2)) fast.
// - Disable keeps divider, both own-address registers and speed select.
// - Writing the data register as transmitter starts shifting that byte.
// - Receiver takes first byte once a status one read clears its flag; each next one after a buffer read.
// - 7-bit mode matches bits 7:1 of address low; bit 0 ignored.
// - Received address 01h is never answered.
// - 10-bit mode: address low gives bits 7:0, address high 2:1 gives 9:8.
// - Frequency range written only while disabled; it sets bus hold delays.
// - Address high resets to 40h; bits 5:3 and 0 read zero.
// - Matched flag rises on own address, or general call when enabled.
// - SCL held low while header, start, byte, matched or sent flags pend.
// ==========================================
// Register indices; byte address is four times the index
`define IDX_CTRL 8'h18
`define IDX_SR1 8'h19
`define IDX_SR2 8'h1A
`define IDX_CCR 8'h1B
`define IDX_OWN_STATION_ID_LOW 8'h1C
`define IDX_OWN_STATION_ID_HIGH 8'h1D
`define IDX_DBUF 8'h1E
`define IDX_IST 8'h20
`define IDX_IMK 8'h21
`define IDX_MODE 8'h22
// ==========================================
// Field positions
`define CT_ON 5
`define CT_GCE 4
`define CT_START 3
`define CT_ACK 2
`define CT_STOP 1
`define CT_IE 0
`define CD_FAST 7
// ==========================================
// Reset values and masks
`define RST_ZERO 8'h00
`define RST_OWN_STATION_ID_HIGH 8'h40
`define OWN_STATION_ID_HIGH_KEEP 8'hC6
// ==========================================
// Timing
`define CLK_NS 50
`define HOLD_FR0_NS 300
`define HOLD_FR1_NS 200
`define HOLD_FR0_CYC ((`HOLD_FR0_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_FR1_CYC ((`HOLD_FR1_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### verilog/i2c_core_pkg.sv
// Types shared by the two-wire interface modules
package i2c_core_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_START = 3'b001,
    PH_RX = 3'b010,
    PH_TX = 3'b011,
    PH_ACK = 3'b100,
    PH_HOLD = 3'b101,
    PH_STOP = 3'b110
  } phase_t;
  typedef enum logic [1:0] {
    CTX_ADDR = 2'b00,
    CTX_TX = 2'b01,
    CTX_RX = 2'b10
  } ctx_t;
  typedef struct packed {
    logic [7:0] ctrl, clock_divider_control, own_station_id_low, own_station_id_high, dbuf, sh, rdata;
    logic [2:0] ist, imk;
    logic mode10, wreq, irq;
    logic sb, long_header_sent_flag, tra, busy, byte_finished_flag, station_matched_flag, ev6, msl, gcal;
    logic hdr, fin, isadr, drv;
    phase_t ph;
    ctx_t ctx;
    logic [3:0] bits, dly;
    logic scl_p, sda_p, sda_oe, scl_oe;
  } core_st_t;
  typedef struct packed {
    logic low;
    logic [8:0] cnt;
  } gen_st_t;
  typedef struct packed {
    logic [1:0] s1, s2;
  } sync_st_t;
endpackage

// ### verilog/i2c_pin_sync.sv
// Two-stage synchroniser for the SCL and SDA pin levels
`timescale 1ns/1ns
module i2c_pin_sync (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [1:0] pins_in,
  output logic [1:0] pins_out
);
  import i2c_core_pkg::*;
  sync_st_t st_r, st_nxt;
  // First stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pins_in;
    st_nxt.s2 = st_r.s1;
  end
  // Idle bus is high, so reset to ones
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) st_r <= {2'b11, 2'b11};
    else st_r <= st_nxt;
  end
  assign pins_out = st_r.s2;
endmodule // i2c_pin_sync

// ### verilog/i2c_scl_gen.sv
// SCL generator: reloading counter with low and high phases
`timescale 1ns/1ns
module i2c_scl_gen (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic run_in,
  input wire logic fast_in,
  input wire logic [6:0] div_in,
  input wire logic scl_bus_in,
  output logic scl_low_out
);
  import i2c_core_pkg::*;
  gen_st_t st_r, st_nxt;
  logic [8:0] n2, low_len;
  // ==========================================
  // Phase counter
  always_comb begin
    n2 = {2'b00, div_in} + 9'h002;
    low_len = fast_in ? {n2[7:0], 1'b0} : n2;
    st_nxt = st_r;
    if (!run_in) begin
      st_nxt.low = 1'b0;
      st_nxt.cnt = 9'h000;
    end else if (st_r.cnt == 9'h000) begin
      st_nxt.low = !st_r.low;
      st_nxt.cnt = st_r.low ? n2 - 9'h001 : low_len - 9'h001;
    end else if (st_r.low | scl_bus_in | (st_r.cnt + 9'h003 >= n2)) begin
      // High phase waits while another party stretches the clock
      // First three high cycles count blind: the pin sync hides the rise
      st_nxt.cnt = st_r.cnt - 9'h001;
    end
  end
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) st_r <= '0;
    else st_r <= st_nxt;
  end
  assign scl_low_out = st_r.low;
  // ==========================================
  // Checks
  gen_low_len_a: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    $rose(st_r.low) |-> st_r.cnt == low_len - 9'h001)
    else $error("SCL low phase length wrong");
  gen_high_len_a: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    run_in && st_r.low && st_r.cnt == 9'h000 ##1 run_in |-> !st_r.low && st_r.cnt == n2 - 9'h001)
    else $error("SCL high phase length wrong");
endmodule // i2c_scl_gen

// ### verilog/i2c_core.sv
// Two-wire bus interface: registers, address match, byte engine
`timescale 1ns/1ns
`include "i2c_core_regs.svh"
module i2c_core (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire i2c_core_pkg::word_t avs_writedata_in,
  output i2c_core_pkg::word_t avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out
);
  import i2c_core_pkg::*;
  core_st_t st_r, st_nxt;
  logic [1:0] pins_s, m;
  logic [7:0] wd;
  logic [3:0] hcyc;
  logic s_scl, s_sda, rise, fall, sta, sto, acc, racc, on, pend, run, gen_low;

  // ==========================================
  // Helpers
  function automatic logic is_at(input logic [7:0] a, input logic [7:0] i);
    return a == {i[5:0], 2'b00};
  endfunction

  // Returns {general call, own address hit}
  function automatic logic [1:0] match_fn(input logic [7:0] b, input logic [7:0] o1,
      input logic [7:0] o2, input logic m10, input logic hdr, input logic gce);
    logic gc, hit;
    gc = (b == 8'h00) & gce & !hdr;
    if (b == 8'h01) hit = 1'b0;
    else if (!m10) hit = b[7:1] == o1[7:1];
    else if (hdr) hit = b == o1;
    else hit = (b[7:3] == 5'h1E) & (b[2:1] == o2[2:1]) & !b[0];
    return {gc, hit};
  endfunction

  function automatic logic [7:0] read_fn(input core_st_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (is_at(a, `IDX_CTRL)) v = s.ctrl;
    if (is_at(a, `IDX_SR1)) begin
      v = {s.sb | s.long_header_sent_flag | s.byte_finished_flag | s.station_matched_flag | s.ev6, s.long_header_sent_flag, s.tra, s.busy,
           s.byte_finished_flag, s.station_matched_flag, s.msl, s.sb};
    end
    if (is_at(a, `IDX_SR2)) v = {7'h00, s.gcal};
    if (is_at(a, `IDX_CCR)) v = s.clock_divider_control;
    if (is_at(a, `IDX_OWN_STATION_ID_LOW)) v = s.own_station_id_low;
    if (is_at(a, `IDX_OWN_STATION_ID_HIGH)) v = s.own_station_id_high & `OWN_STATION_ID_HIGH_KEEP;
    if (is_at(a, `IDX_DBUF)) v = s.dbuf;
    if (is_at(a, `IDX_IST)) v = {5'h00, s.ist};
    if (is_at(a, `IDX_IMK)) v = {5'h00, s.imk};
    if (is_at(a, `IDX_MODE)) v = {7'h00, s.mode10};
    return v;
  endfunction

  // ==========================================
  // Pins and clock generator
  i2c_pin_sync u_sync (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .pins_in({scl_in, sda_in}),
    .pins_out(pins_s)
  );

  // Clock runs only while master and no flag stretches the bus
  assign run = st_r.msl & on & !pend & (st_r.ph != PH_HOLD);
  i2c_scl_gen u_gen (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .run_in(run),
    .fast_in(st_r.clock_divider_control[`CD_FAST]),
    .div_in(st_r.clock_divider_control[6:0]),
    .scl_bus_in(s_scl),
    .scl_low_out(gen_low)
  );

  assign s_scl = pins_s[1];
  assign s_sda = pins_s[0];
  assign rise = s_scl & !st_r.scl_p;
  assign fall = !s_scl & st_r.scl_p;
  assign sta = s_scl & st_r.scl_p & st_r.sda_p & !s_sda;
  assign sto = s_scl & st_r.scl_p & !st_r.sda_p & s_sda;
  assign on = st_r.ctrl[`CT_ON];
  assign pend = st_r.sb | st_r.long_header_sent_flag | st_r.byte_finished_flag | st_r.station_matched_flag | st_r.ev6;
  assign acc = (avs_read_in | avs_write_in) & !st_r.wreq;
  // Read clears act where data is captured, so no flag is lost unseen
  assign racc = avs_read_in & st_r.wreq;
  assign wd = avs_writedata_in[7:0];
  // Range code 00 needs the longer hold; other codes use the shorter
  assign hcyc = (st_r.own_station_id_high[7:6] == 2'b00) ? 4'(`HOLD_FR0_CYC) : 4'(`HOLD_FR1_CYC);
  assign m = match_fn(st_r.sh, st_r.own_station_id_low, st_r.own_station_id_high, st_r.mode10, st_r.hdr,
                      st_r.ctrl[`CT_GCE]);

  // ==========================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_p = s_scl;
    st_nxt.sda_p = s_sda;
    if (sta) st_nxt.busy = 1'b1;
    else if (sto) st_nxt.busy = 1'b0;

    // Bus slave: one wait cycle, then the access commits
    if ((avs_read_in | avs_write_in) & st_r.wreq) begin
      st_nxt.wreq = 1'b0;
      st_nxt.rdata = avs_read_in ? read_fn(st_r, avs_address_in) : 8'h00;
    end else begin
      st_nxt.wreq = 1'b1;
    end
    if (acc & avs_write_in) begin
      if (is_at(avs_address_in, `IDX_CTRL)) st_nxt.ctrl = {2'b00, wd[5:0]};
      if (is_at(avs_address_in, `IDX_CCR)) st_nxt.clock_divider_control = wd;
      if (is_at(avs_address_in, `IDX_OWN_STATION_ID_LOW)) st_nxt.own_station_id_low = wd;
      if (is_at(avs_address_in, `IDX_OWN_STATION_ID_HIGH)) begin
        // Range is frozen while enabled so delays never change mid-frame
        st_nxt.own_station_id_high = {on ? st_r.own_station_id_high[7:6] : wd[7:6], 3'b000, wd[2:1], 1'b0};
      end
      if (is_at(avs_address_in, `IDX_IST)) st_nxt.ist = st_r.ist & ~wd[2:0];
      if (is_at(avs_address_in, `IDX_IMK)) st_nxt.imk = wd[2:0];
      if (is_at(avs_address_in, `IDX_MODE)) st_nxt.mode10 = wd[0];
      if (is_at(avs_address_in, `IDX_DBUF)) begin
        st_nxt.dbuf = wd;
        st_nxt.sb = 1'b0;
        st_nxt.long_header_sent_flag = 1'b0;
        st_nxt.byte_finished_flag = 1'b0;
        if (st_r.ph == PH_HOLD && (st_r.msl | st_r.tra)) begin
          st_nxt.ph = PH_TX;
          st_nxt.ctx = CTX_TX;
          st_nxt.sh = wd;
          st_nxt.bits = 4'h0;
          st_nxt.dly = hcyc;
          st_nxt.isadr = st_r.sb | st_r.long_header_sent_flag;
        end
      end
    end
    if (racc) begin
      if (is_at(avs_address_in, `IDX_SR1)) begin
        st_nxt.station_matched_flag = 1'b0;
        st_nxt.ev6 = 1'b0;
      end
      if (is_at(avs_address_in, `IDX_DBUF) & !st_r.tra) st_nxt.byte_finished_flag = 1'b0;
    end

    // Byte engine
    unique case (st_r.ph)
      PH_IDLE: begin
        if (on & st_r.ctrl[`CT_START] & !st_r.busy) begin
          st_nxt.ph = PH_START;
          st_nxt.sda_oe = 1'b1;
          st_nxt.dly = hcyc;
        end else if (on & sta) begin
          st_nxt.ph = PH_RX;
          st_nxt.ctx = CTX_ADDR;
          st_nxt.bits = 4'h0;
          st_nxt.hdr = 1'b0;
        end
      end
      PH_START: begin
        if (st_r.dly > 4'h1) begin
          st_nxt.dly = st_r.dly - 4'h1;
        end else begin
          st_nxt.sb = 1'b1;
          st_nxt.msl = 1'b1;
          st_nxt.tra = 1'b0;
          st_nxt.hdr = 1'b0;
          st_nxt.ctrl[`CT_START] = 1'b0;
          st_nxt.ph = PH_HOLD;
        end
      end
      PH_RX: begin
        if (rise) begin
          st_nxt.sh = {st_r.sh[6:0], s_sda};
          st_nxt.bits = st_r.bits + 4'h1;
        end else if (fall && st_r.bits == 4'h8) begin
          st_nxt.bits = 4'h0;
          st_nxt.dly = hcyc;
          st_nxt.ph = PH_ACK;
          st_nxt.drv = st_r.ctrl[`CT_ACK];
          if (st_r.ctx == CTX_ADDR) begin
            st_nxt.fin = m[1] | (m[0] & !(st_r.mode10 & !st_r.hdr));
            st_nxt.hdr = st_r.mode10 & !st_r.hdr & m[0];
            st_nxt.gcal = st_r.gcal | m[1];
            if (m == 2'b00) begin
              st_nxt.ph = PH_IDLE;
              st_nxt.drv = 1'b0;
            end
          end
        end
      end
      PH_TX: begin
        if (st_r.dly != 4'h0) begin
          st_nxt.dly = st_r.dly - 4'h1;
          if (st_r.dly == 4'h1) st_nxt.sda_oe = !st_r.sh[7];
        end else if (fall) begin
          st_nxt.sh = {st_r.sh[6:0], 1'b0};
          st_nxt.bits = st_r.bits + 4'h1;
          st_nxt.dly = hcyc;
          if (st_r.bits == 4'h7) begin
            st_nxt.ph = PH_ACK;
            st_nxt.drv = 1'b0;
          end
        end
      end
      PH_ACK: begin
        if (st_r.dly != 4'h0) begin
          st_nxt.dly = st_r.dly - 4'h1;
          if (st_r.dly == 4'h1) st_nxt.sda_oe = st_r.drv;
        end else if (fall) begin
          st_nxt.sda_oe = 1'b0;
          st_nxt.ph = PH_HOLD;
          unique case (st_r.ctx)
            CTX_ADDR: begin
              if (st_r.fin) begin
                st_nxt.station_matched_flag = 1'b1;
                st_nxt.tra = st_r.mode10 ? 1'b0 : st_r.sh[0];
              end else begin
                st_nxt.ph = PH_RX;
              end
            end
            CTX_TX: begin
              if (st_r.isadr && !st_r.hdr && st_r.dbuf[7:3] == 5'h1E && !st_r.dbuf[0]) begin
                st_nxt.long_header_sent_flag = 1'b1;
                st_nxt.hdr = 1'b1;
                st_nxt.tra = 1'b1;
              end else if (st_r.isadr) begin
                st_nxt.ev6 = 1'b1;
                st_nxt.tra = st_r.hdr | !st_r.dbuf[0];
              end else begin
                st_nxt.byte_finished_flag = 1'b1;
                st_nxt.tra = 1'b1;
              end
            end
            CTX_RX: begin
              st_nxt.dbuf = st_r.sh;
              st_nxt.byte_finished_flag = 1'b1;
              st_nxt.tra = 1'b0;
            end
            default: st_nxt.ph = PH_IDLE;
          endcase
        end
      end
      PH_HOLD: begin
        if (st_nxt.ph == PH_HOLD && !pend) begin
          if (st_r.msl & st_r.ctrl[`CT_STOP]) begin
            st_nxt.ph = PH_STOP;
            st_nxt.sda_oe = 1'b1;
            st_nxt.dly = hcyc;
          end else if (!st_r.tra) begin
            st_nxt.ph = PH_RX;
            st_nxt.ctx = CTX_RX;
            st_nxt.bits = 4'h0;
          end
        end
      end
      PH_STOP: begin
        if (st_r.dly != 4'h0) begin
          st_nxt.dly = st_r.dly - 4'h1;
        end else if (s_scl) begin
          st_nxt.sda_oe = 1'b0;
          st_nxt.ctrl[`CT_STOP] = 1'b0;
        end
      end
      default: st_nxt.ph = PH_IDLE;
    endcase

    if (sto) begin
      st_nxt.gcal = 1'b0;
      st_nxt.tra = 1'b0;
      st_nxt.msl = 1'b0;
      st_nxt.hdr = 1'b0;
      st_nxt.sda_oe = 1'b0;
      st_nxt.ph = PH_IDLE;
    end

    // Events are sticky; a same-cycle clear loses to the set
    st_nxt.ist = st_nxt.ist | {st_nxt.sb & !st_r.sb, st_nxt.station_matched_flag & !st_r.station_matched_flag,
                               st_nxt.byte_finished_flag & !st_r.byte_finished_flag};

    // Disable drops bus state and the start, ack and IE control bits; divider and addresses stay
    if (!st_nxt.ctrl[`CT_ON]) begin
      st_nxt.sb = 1'b0;
      st_nxt.long_header_sent_flag = 1'b0;
      st_nxt.byte_finished_flag = 1'b0;
      st_nxt.station_matched_flag = 1'b0;
      st_nxt.ev6 = 1'b0;
      st_nxt.msl = 1'b0;
      st_nxt.tra = 1'b0;
      st_nxt.gcal = 1'b0;
      st_nxt.hdr = 1'b0;
      st_nxt.sda_oe = 1'b0;
      st_nxt.ph = PH_IDLE;
      st_nxt.ctrl[`CT_START] = 1'b0;
      st_nxt.ctrl[`CT_ACK] = 1'b0;
      st_nxt.ctrl[`CT_IE] = 1'b0;
    end

    // Stretch covers pending flags and a transmitter waiting for data
    st_nxt.scl_oe = st_nxt.ctrl[`CT_ON] & ((st_nxt.sb | st_nxt.long_header_sent_flag | st_nxt.byte_finished_flag
                    | st_nxt.station_matched_flag | st_nxt.ev6)
                    | st_nxt.ph == PH_HOLD
                    | (st_nxt.ph == PH_TX && st_nxt.bits == 4'h0 && st_nxt.dly != 4'h0)
                    | (st_nxt.ph == PH_STOP && st_nxt.dly != 4'h0)
                    | (st_r.msl & gen_low));
    st_nxt.irq = |(st_nxt.ist & st_nxt.imk);
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
      st_r.own_station_id_high <= `RST_OWN_STATION_ID_HIGH;
      st_r.wreq <= 1'b1;
      st_r.scl_p <= 1'b1;
      st_r.sda_p <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata_out = {24'h000000, st_r.rdata};
  assign avs_waitrequest_out = st_r.wreq;
  assign irq_out = st_r.irq;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = st_r.scl_oe;
  assign sda_oe_out = st_r.sda_oe;

  // ==========================================
  // Checks
  hold_on_match_a: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    st_r.ctrl[`CT_ON] && (st_r.station_matched_flag || st_r.byte_finished_flag || st_r.sb) |-> st_r.scl_oe)
    else $error("SCL not held while a flag pends");
  never_addr01_a: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    $rose(st_r.station_matched_flag) |-> st_r.sh != 8'h01)
    else $error("Address 01h was answered");
  seven_bit_a: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    $rose(st_r.station_matched_flag) && !st_r.mode10 && !st_r.gcal |-> st_r.sh[7:1] == st_r.own_station_id_low[7:1])
    else $error("7-bit match on wrong address");
  keep_on_off_a: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    $fell(st_r.ctrl[`CT_ON]) |-> st_r.clock_divider_control == $past(st_r.clock_divider_control) && st_r.own_station_id_low == $past(st_r.own_station_id_low))
    else $error("Disable changed kept settings");
  tx_launch_a: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    acc && avs_write_in && is_at(avs_address_in, `IDX_DBUF) && st_r.ph == PH_HOLD
    && st_r.tra && st_nxt.ctrl[`CT_ON] |=> st_r.ph == PH_TX ##[1:40] st_r.sda_oe == !st_r.sh[7])
    else $error("Buffer write did not launch a byte");
  rx_pace_a: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    st_r.ph == PH_HOLD && st_r.byte_finished_flag && !st_r.tra && st_r.ctrl[`CT_ON] |=> st_r.ph == PH_HOLD)
    else $error("Next byte received before buffer read");
  range_frozen_a: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    st_r.ctrl[`CT_ON] ##1 st_r.ctrl[`CT_ON] |-> st_r.own_station_id_high[7:6] == $past(st_r.own_station_id_high[7:6]))
    else $error("Range changed while enabled");
endmodule // i2c_core

// ### test/i2c_bus_peer.sv
// Behavioural far-side bus master driving the two-wire pins
`timescale 1ns/1ns
module i2c_bus_peer (
  input wire logic core_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe_out,
  output logic sda_oe_out
);
  // ==========================
  // Bit timing; stretching by the device is waited out, bounded
  localparam int HALF = 30;
  int stalls = 0;
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic let_go();
    int n;
    n = 0;
    scl_oe_out <= 1'b0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (scl_in !== 1'b1 && n < 5000);
    if (n >= 5000) stalls++;
  endtask
  // SDA only moves while SCL is low
  task automatic clock_bit(input logic d, output logic q);
    sda_oe_out <= !d;
    pause(HALF);
    let_go();
    pause(HALF);
    q = sda_in;
    scl_oe_out <= 1'b1;
    pause(HALF / 2);
  endtask
  task automatic start_cond();
    sda_oe_out <= 1'b1;
    pause(HALF);
    scl_oe_out <= 1'b1;
    pause(HALF / 2);
  endtask
  task automatic stop_cond();
    scl_oe_out <= 1'b1;
    pause(HALF / 2);
    sda_oe_out <= 1'b1;
    pause(HALF);
    let_go();
    pause(HALF);
    sda_oe_out <= 1'b0;
    pause(HALF);
  endtask
  // Byte taken in by the device only once the previous one has been read
  task automatic put(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], q);
    clock_bit(1'b1, ack);
  endtask
  // Next byte asked for only after the previous one is taken
  task automatic get(input logic nak, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
    clock_bit(nak, q);
  endtask
endmodule // i2c_bus_peer

// ### test/i2c_clock_address_data_regs_bench.sv
// Self-checking bench for the two-wire interface registers and addressing
`timescale 1ns/1ns
module i2c_clock_address_data_regs_bench;
  import i2c_core_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  word_t avs_writedata = 32'h0;
  word_t avs_readdata;
  logic avs_waitrequest, irq, dut_scl_oe, dut_sda_oe, peer_scl_oe, peer_sda_oe;
  // Pull-ups: a released line reads high
  wire scl_w = ~(dut_scl_oe | peer_scl_oe);
  wire sda_w = ~(dut_sda_oe | peer_sda_oe);
  int failures = 0;
  int cmp_count = 0;
  always #25 core_clk = ~core_clk;
  i2c_core dut_u (.core_clk_in(core_clk), .arst_n_in(arst_n), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
    .irq_out(irq), .scl_in(scl_w), .scl_out(), .scl_oe_out(dut_scl_oe), .sda_in(sda_w),
    .sda_out(), .sda_oe_out(dut_sda_oe));
  i2c_bus_peer peer_u (.core_clk_in(core_clk), .scl_in(scl_w), .sda_in(sda_w),
    .scl_oe_out(peer_scl_oe), .sda_oe_out(peer_sda_oe));
  // ==========================
  // Report and compare
  task automatic wrap_up();
    failures += peer_u.stalls;
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ==========================
  // Register bus cycles
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (n >= 200) begin
      failures++;
      wrap_up();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, exp, q);
  endtask
  // Polls status one; polling itself clears the matched flag
  task automatic wait_flag(input logic [7:0] m);
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h00;
    while ((q & m) !== m && n < 1000) begin
      bus(1'b0, 8'h64, 8'h00, q);
      n++;
    end
    if (n >= 1000) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic irq_is(input string what, input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    chk(what, {7'h00, v}, {7'h00, irq});
  endtask
  task automatic wait_oe(input logic v, inout int n);
    while (dut_scl_oe !== v && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      wrap_up();
    end
  endtask
  // ==========================
  // Scenarios
  task automatic t_reset();
    rd("divider", 8'h6C, 8'h00);
    rd("id_low", 8'h70, 8'h00);
    rd("id_high", 8'h74, 8'h40);
    rd("buffer", 8'h78, 8'h00);
    wr(8'h90, 8'hFF);
    rd("unmapped", 8'h90, 8'h00);
  endtask
  task automatic t_keep();
    wr(8'h74, 8'hFF);
    rd("id_high bits", 8'h74, 8'hC6);
    wr(8'h6C, 8'h85);
    wr(8'h70, 8'hA5);
    wr(8'h60, 8'h20);
    wr(8'h74, 8'h00);
    rd("range while on", 8'h74, 8'hC0);
    wr(8'h60, 8'h00);
    rd("divider kept", 8'h6C, 8'h85);
    rd("id_low kept", 8'h70, 8'hA5);
    rd("id_high kept", 8'h74, 8'hC0);
    wr(8'h74, 8'h40);
    rd("range while off", 8'h74, 8'h40);
  endtask
  task automatic t_slave_rx();
    logic a0, a1, a2;
    wr(8'h60, 8'h24);
    fork
      begin
        peer_u.start_cond();
        peer_u.put(8'hA4, a0);
        peer_u.put(8'h5A, a1);
        peer_u.put(8'h3C, a2);
        peer_u.stop_cond();
      end
      begin
        wait_flag(8'h04);
        rd("irq status", 8'h80, 8'h02);
        irq_is("irq masked", 1'b0);
        wr(8'h84, 8'h02);
        irq_is("irq raised", 1'b1);
        wr(8'h80, 8'h02);
        irq_is("irq cleared", 1'b0);
        wr(8'h84, 8'h00);
        wait_flag(8'h08);
        repeat (100) @(posedge core_clk);
        chk("scl held", 8'h00, {7'h00, scl_w});
        rd("first byte", 8'h78, 8'h5A);
        wait_flag(8'h08);
        rd("second byte", 8'h78, 8'h3C);
      end
    join
    chk("rx acks", 8'h00, {5'h00, a0, a1, a2});
  endtask
  // Mismatch, address 01h, general call on and off
  task automatic t_addr();
    logic [7:0] oa [4] = '{8'hA5, 8'h00, 8'h02, 8'h02};
    logic [7:0] ct [4] = '{8'h24, 8'h24, 8'h34, 8'h24};
    logic [7:0] ad [4] = '{8'hA6, 8'h01, 8'h00, 8'h00};
    logic nak [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    logic a;
    logic [7:0] q;
    for (int i = 0; i < 4; i++) begin
      wr(8'h70, oa[i]);
      wr(8'h60, ct[i]);
      peer_u.start_cond();
      peer_u.put(ad[i], a);
      chk("addr ack", {7'h00, nak[i]}, {7'h00, a});
      repeat (8) @(posedge core_clk);
      bus(1'b0, 8'h64, 8'h00, q);
      chk("matched", {5'h00, !nak[i], 2'h0}, q & 8'h04);
      peer_u.stop_cond();
    end
  endtask
  task automatic t_slave_tx();
    logic a;
    logic [7:0] b;
    wr(8'h70, 8'hA5);
    fork
      begin
        peer_u.start_cond();
        peer_u.put(8'hA5, a);
        peer_u.get(1'b1, b);
        peer_u.stop_cond();
      end
      begin
        wait_flag(8'h04);
        wr(8'h78, 8'h96);
        wait_flag(8'h08);
        wr(8'h60, 8'h00);
        wr(8'h60, 8'h24);
      end
    join
    chk("tx ack", 8'h00, {7'h00, a});
    chk("tx byte", 8'h96, b);
  endtask
  task automatic t_long();
    logic a;
    wr(8'h88, 8'h01);
    wr(8'h74, 8'h44);
    wr(8'h70, 8'h5C);
    peer_u.start_cond();
    peer_u.put(8'hF4, a);
    chk("long head ack", 8'h00, {7'h00, a});
    peer_u.put(8'h5C, a);
    chk("long ack", 8'h00, {7'h00, a});
    wait_flag(8'h04);
    peer_u.stop_cond();
    wr(8'h88, 8'h00);
  endtask
  // One full SCL period measured mid-address
  task automatic t_master(input logic [7:0] div, input logic [7:0] per);
    int n, t;
    n = 0;
    wr(8'h60, 8'h00);
    wr(8'h6C, div);
    wr(8'h60, 8'h28);
    wait_flag(8'h01);
    repeat (40) @(posedge core_clk);
    chk("start hold", 8'h01, {7'h00, dut_scl_oe});
    wr(8'h78, 8'hB0);
    wait_oe(1'b0, n);
    wait_oe(1'b1, n);
    t = n;
    wait_oe(1'b0, n);
    wait_oe(1'b1, n);
    chk("scl period", per, 8'(n - t));
    wr(8'h60, 8'h00);
    peer_u.stop_cond();
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_keep();
    t_slave_rx();
    t_addr();
    t_slave_tx();
    t_long();
    t_master(8'h08, 8'h14);
    t_master(8'h88, 8'h1E);
    wrap_up();
  end
endmodule // i2c_clock_address_data_regs_bench
